// ### hdl/line_cfg.svh
// Offsets, field positions, reset values and timing counts for the line register bank.
// What this block does
// - Bit 7 of calibration register reads 1 while resistor calibration runs.
// - Writing manual calibration start bit from 0 to 1 while the sequencer is idle begins a manual calibration.
// - Calibration inhibit bit at 1 suppresses resistor calibration; 0 allows it.
// - Bits 7:6 select termination pin voltage 3.1, 3.2, 3.35 or 3.5 V.
// - Bits 5:4 select minimum loop current 10, 12, 14 or 16 mA.
// - Current-limit enable bit at 1 caps loop current at 60 mA.
// - Bit 0 selects 50 ohm (0) or 800 ohm (1) DC termination.
// - Loop current status is unsigned eight bits, 1.1 mA per count.
// - Loop current status reads zero when loop current is too low.
// - Line voltage status is two's complement, 1 V per count, any hook state.
// - Line voltage MSB shows polarity; its change marks a polarity reversal.
// - Line voltage status reads zero when no line is connected.
`ifndef LINE_CFG_SVH
`define LINE_CFG_SVH

// Register indices; the byte address is four times the index.
`define IDX_CAL        6'h19
`define IDX_DCT        6'h1A
`define IDX_RSVD       6'h1B
`define IDX_LOOP       6'h1C
`define IDX_VOLT       6'h1D
`define IDX_IRQ_STAT   6'h20
`define IDX_IRQ_MASK   6'h21

// Calibration register fields.
`define CAL_ACTIVE_BIT  7
`define CAL_START_BIT   6
`define CAL_INHIBIT_BIT 5
`define CAL_SPARE_BIT   4

// DC termination register fields.
`define DCT_VOLT_HI  7
`define DCT_VOLT_LO  6
`define DCT_MIN_HI   5
`define DCT_MIN_LO   4
`define DCT_CURRENT_LIMIT_EN_BIT 1
`define DCT_IMP_BIT  0

// Interrupt status bits.
`define IRQ_CAL_DONE  0
`define IRQ_POL_REV   1
`define IRQ_LOOP_LOST 2
`define IRQ_LINE_LOST 3
`define IRQ_BITS      4

// Reset values.
`define CAL_RESET  8'h00
`define DCT_RESET  8'h00
`define MASK_RESET 4'h0

// Calibration run time and the clock rate it is counted at.
`define CLK_HZ      20000000
`define CAL_TIME_US 100

`endif

// ### hdl/line_pkg.sv
// Types shared by the line register bank modules.
package line_pkg;
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_RUN  = 2'b01,
		CAL_DONE = 2'b10
	} cal_state_t;

	typedef enum logic [1:0] {
		RESP_OKAY   = 2'b00,
		RESP_SLVERR = 2'b10
	} axi_resp_t;
endpackage : line_pkg

// ### hdl/sync2.sv
// Two-flop synchroniser for levels arriving from the line side.
module sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Asynchronous level in, synchronised level out.
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule : sync2

// ### hdl/cal_seq.sv
// Resistor calibration sequencer: runs one timed calibration and captures its trim result.
`include "line_cfg.svh"
module cal_seq #(
	parameter int CAL_CYCLES = 2000
) (
	// Clock and reset.
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Requests from the register bank.
	input  wire logic       manual_cal_start,
	input  wire logic       cal_inhibit,
	// Trim code from the line side, already synchronised.
	input  wire logic [3:0] trim_in,
	// Status back to the register bank.
	output logic            calib_active,
	output logic            cal_done,
	output logic [3:0]      cal_result
);
	line_pkg::cal_state_t state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic        start_prev_q;
	logic        auto_pend_q, auto_pend_d;
	logic [3:0]  result_q, result_d;
	logic        go;

	// A rising start bit or the power-up request starts a run unless inhibited.
	assign go = !cal_inhibit && ((manual_cal_start && !start_prev_q) || auto_pend_q);

	// Next state of the sequencer.
	always_comb begin
		state_d     = state_q;
		cnt_d       = cnt_q;
		auto_pend_d = auto_pend_q;
		result_d    = result_q;
		case (state_q)
			line_pkg::CAL_IDLE: begin
				if (go) begin
					state_d     = line_pkg::CAL_RUN;
					cnt_d       = 16'(CAL_CYCLES - 1);
					auto_pend_d = 1'b0;
				end
			end
			line_pkg::CAL_RUN: begin
				if (cnt_q == 16'h0000) begin
					state_d  = line_pkg::CAL_DONE;
					result_d = trim_in;
				end else begin
					cnt_d = cnt_q - 16'h0001;
				end
			end
			line_pkg::CAL_DONE: state_d = line_pkg::CAL_IDLE;
			default:            state_d = line_pkg::CAL_IDLE;
		endcase
	end

	// Registers of the sequencer; auto calibration is requested once after reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q      <= line_pkg::CAL_IDLE;
			cnt_q        <= 16'h0000;
			start_prev_q <= 1'b0;
			auto_pend_q  <= 1'b1;
			result_q     <= 4'h0;
		end else begin
			state_q      <= state_d;
			cnt_q        <= cnt_d;
			start_prev_q <= manual_cal_start;
			auto_pend_q  <= auto_pend_d;
			result_q     <= result_d;
		end
	end

	assign calib_active = (state_q == line_pkg::CAL_RUN);
	assign cal_done     = (state_q == line_pkg::CAL_DONE);
	assign cal_result   = result_q;
endmodule : cal_seq

// ### hdl/line_regs.sv
// AXI4-Lite register bank for calibration, DC termination and line monitoring.
//
// Design decision made here: register access over AXI4-Lite.
`include "line_cfg.svh"
module line_regs #(
	parameter int CAL_CYCLES = (`CAL_TIME_US * (`CLK_HZ / 1000000))
) (
	// Clock and reset.
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// AXI4-Lite write address channel.
	input  wire logic       s_axi_awvalid,
	output logic            s_axi_awready,
	input  wire logic [7:0] s_axi_awaddr,
	// AXI4-Lite write data channel.
	input  wire logic       s_axi_wvalid,
	output logic            s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response channel.
	output logic            s_axi_bvalid,
	input  wire logic       s_axi_bready,
	output logic [1:0]      s_axi_bresp,
	// AXI4-Lite read address channel.
	input  wire logic       s_axi_arvalid,
	output logic            s_axi_arready,
	input  wire logic [7:0] s_axi_araddr,
	// AXI4-Lite read data channel.
	output logic            s_axi_rvalid,
	input  wire logic       s_axi_rready,
	output logic [31:0]     s_axi_rdata,
	output logic [1:0]      s_axi_rresp,
	// Interrupt.
	output logic            irq,
	// Settings driven to the line side.
	output logic [1:0]      tipring_volt_sel,
	output logic [1:0]      min_loop_sel,
	output logic            current_limit_en,
	output logic            dc_impedance_sel,
	output logic            cal_run,
	// Measurements from the line side, asynchronous.
	input  wire logic [7:0] loop_current_in,
	input  wire logic [7:0] line_voltage_in,
	input  wire logic       loop_ok_in,
	input  wire logic       line_present_in,
	input  wire logic [3:0] cal_trim_in
);
	// Register state.
	logic [7:0]            cal_q, cal_d;
	logic [7:0]            dct_q, dct_d;
	logic [7:0]            loop_q, loop_d;
	logic [7:0]            volt_q, volt_d;
	logic [`IRQ_BITS-1:0]  stat_q, stat_d;
	logic [`IRQ_BITS-1:0]  mask_q, mask_d;
	logic                  meas_init_q, meas_init_d;
	logic                  line_prev_q, line_prev_d;

	// Bus channel state.
	logic        aw_full_q, aw_full_d;
	logic        w_full_q, w_full_d;
	logic [5:0]  aw_idx_q, aw_idx_d;
	logic [7:0]  w_byte_q, w_byte_d;
	logic        w_lane_q, w_lane_d;
	logic        bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d;
	logic        rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;

	// Synchronised line-side levels.
	logic [7:0] loop_s;
	logic [7:0] volt_s;
	logic       loop_ok_s;
	logic       line_present_s;
	logic [3:0] trim_s;

	// Calibration sequencer outputs.
	logic       calib_active;
	logic       cal_done;
	logic [3:0] cal_result;

	// Decoded transfer strobes.
	logic       wr_fire;
	logic       rd_fire;
	logic [5:0] ar_idx;
	logic [7:0] rd_byte;
	logic       rd_hit;
	logic       wr_hit;
	logic [7:0] loop_meas;
	logic [7:0] volt_meas;

	// Every line-side input passes two flops before any logic looks at it.
	// A multi-bit value caught mid-change may show one mixed sample; the next cycle
	// corrects it, which is acceptable for slowly moving line measurements.
	sync2 #(.WIDTH(22)) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({loop_current_in, line_voltage_in, loop_ok_in, line_present_in, cal_trim_in}),
		.sync_out ({loop_s, volt_s, loop_ok_s, line_present_s, trim_s})
	);

	cal_seq #(.CAL_CYCLES(CAL_CYCLES)) u_cal (
		.aclk             (aclk),
		.aresetn          (aresetn),
		.manual_cal_start (cal_q[`CAL_START_BIT]),
		.cal_inhibit      (cal_q[`CAL_INHIBIT_BIT]),
		.trim_in          (trim_s),
		.calib_active     (calib_active),
		.cal_done         (cal_done),
		.cal_result       (cal_result)
	);

	// The monitor values are forced to zero while there is no loop or no line.
	assign loop_meas = loop_ok_s ? loop_s : 8'h00;
	assign volt_meas = line_present_s ? volt_s : 8'h00;

	// A write happens once both halves are held and no response is pending.
	// Waiting for the response to leave keeps one write in flight; a second address
	// simply waits in its holding register.
	assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
	assign rd_fire = s_axi_arvalid && !rvalid_q;
	assign ar_idx  = s_axi_araddr[7:2];

	// Read multiplexer; the calibration busy flag is live, not stored.
	// The index comes from the live address, so the master must hold araddr until taken.
	always_comb begin
		rd_byte = 8'h00;
		rd_hit  = 1'b1;
		case (ar_idx)
			`IDX_CAL:      rd_byte = {calib_active, cal_q[6:0]};
			`IDX_DCT:      rd_byte = dct_q;
			`IDX_RSVD:     rd_byte = 8'h00;
			`IDX_LOOP:     rd_byte = loop_q;
			`IDX_VOLT:     rd_byte = volt_q;
			`IDX_IRQ_STAT: rd_byte = {{(8-`IRQ_BITS){1'b0}}, stat_q};
			`IDX_IRQ_MASK: rd_byte = {{(8-`IRQ_BITS){1'b0}}, mask_q};
			default:       rd_hit  = 1'b0;
		endcase
	end

	// Write address decode; only listed indices answer OKAY.
	always_comb begin
		case (aw_idx_q)
			`IDX_CAL, `IDX_DCT, `IDX_RSVD, `IDX_LOOP,
			`IDX_VOLT, `IDX_IRQ_STAT, `IDX_IRQ_MASK: wr_hit = 1'b1;
			default:                                 wr_hit = 1'b0;
		endcase
	end

	// Write address and data are taken independently, in either order.
	always_comb begin
		aw_full_d = aw_full_q;
		aw_idx_d  = aw_idx_q;
		w_full_d  = w_full_q;
		w_byte_d  = w_byte_q;
		w_lane_d  = w_lane_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		if (s_axi_awvalid && !aw_full_q) begin
			aw_full_d = 1'b1;
			aw_idx_d  = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && !w_full_q) begin
			w_full_d = 1'b1;
			w_byte_d = s_axi_wdata[7:0];
			w_lane_d = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wr_hit ? line_pkg::RESP_OKAY : line_pkg::RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
	end

	// Read data is registered; a new address is taken only once the last answer left.
	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (rd_fire) begin
			rvalid_d = 1'b1;
			rdata_d  = {24'h000000, rd_byte};
			rresp_d  = rd_hit ? line_pkg::RESP_OKAY : line_pkg::RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	// Register file update, measurement capture and sticky events.
	// Event detection starts one cycle after reset so cleared registers give no false edge.
	always_comb begin
		cal_d       = cal_q;
		dct_d       = dct_q;
		mask_d      = mask_q;
		stat_d      = stat_q;
		loop_d      = loop_meas;
		volt_d      = volt_meas;
		meas_init_d = 1'b1;
		line_prev_d = line_present_s;
		// A finished calibration replaces the result field.
		if (cal_done) begin
			cal_d[3:0] = cal_result;
		end
		if (wr_fire && w_lane_q) begin
			case (aw_idx_q)
				`IDX_CAL: begin
					// The busy bit is read-only; the result field is taken as written unless a calibration finishes in the same cycle.
					cal_d[6:4] = w_byte_q[6:4];
					if (!cal_done) begin
						cal_d[3:0] = w_byte_q[3:0];
					end
				end
				`IDX_DCT:      dct_d  = w_byte_q;
				`IDX_IRQ_MASK: mask_d = w_byte_q[`IRQ_BITS-1:0];
				default:       dct_d  = dct_q;
			endcase
		end
		// Reading the status register clears it; an event in the same cycle survives.
		if (rd_fire && (ar_idx == `IDX_IRQ_STAT)) begin
			stat_d = '0;
		end
		if (cal_done) begin
			stat_d[`IRQ_CAL_DONE] = 1'b1;
		end
		// A line that has just appeared is not a reversal: its sign would be compared
		// with the zero read while it was absent, so both cycles must see the line.
		if (meas_init_q && line_prev_q && line_present_s && (volt_meas[7] != volt_q[7])) begin
			stat_d[`IRQ_POL_REV] = 1'b1;
		end
		if (meas_init_q && (loop_q != 8'h00) && (loop_meas == 8'h00)) begin
			stat_d[`IRQ_LOOP_LOST] = 1'b1;
		end
		if (meas_init_q && (volt_q != 8'h00) && !line_present_s) begin
			stat_d[`IRQ_LINE_LOST] = 1'b1;
		end
	end

	// All registers of the bank.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cal_q       <= `CAL_RESET;
			dct_q       <= `DCT_RESET;
			loop_q      <= 8'h00;
			volt_q      <= 8'h00;
			stat_q      <= '0;
			mask_q      <= `MASK_RESET;
			meas_init_q <= 1'b0;
			line_prev_q <= 1'b0;
			aw_full_q   <= 1'b0;
			aw_idx_q    <= 6'h00;
			w_full_q    <= 1'b0;
			w_byte_q    <= 8'h00;
			w_lane_q    <= 1'b0;
			bvalid_q    <= 1'b0;
			bresp_q     <= 2'h0;
			rvalid_q    <= 1'b0;
			rdata_q     <= 32'h00000000;
			rresp_q     <= 2'h0;
		end else begin
			cal_q       <= cal_d;
			dct_q       <= dct_d;
			loop_q      <= loop_d;
			volt_q      <= volt_d;
			stat_q      <= stat_d;
			mask_q      <= mask_d;
			meas_init_q <= meas_init_d;
			line_prev_q <= line_prev_d;
			aw_full_q   <= aw_full_d;
			aw_idx_q    <= aw_idx_d;
			w_full_q    <= w_full_d;
			w_byte_q    <= w_byte_d;
			w_lane_q    <= w_lane_d;
			bvalid_q    <= bvalid_d;
			bresp_q     <= bresp_d;
			rvalid_q    <= rvalid_d;
			rdata_q     <= rdata_d;
			rresp_q     <= rresp_d;
		end
	end

	// Bus handshake outputs.
	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready  = !w_full_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// One level interrupt while any unmasked event is pending.
	// It stays high until software reads the status register or masks the event.
	assign irq = |(stat_q & mask_q);

	// Settings to the line side come straight from the stored fields; cal_run is the sequencer's busy flag.
	// Bits 3:2 are kept as written, so a host that breaks the write-zero rule reads its
	// own value back instead of a silent zero.
	assign tipring_volt_sel = dct_q[`DCT_VOLT_HI:`DCT_VOLT_LO];
	assign min_loop_sel     = dct_q[`DCT_MIN_HI:`DCT_MIN_LO];
	assign current_limit_en = dct_q[`DCT_CURRENT_LIMIT_EN_BIT];
	assign dc_impedance_sel = dct_q[`DCT_IMP_BIT];
	assign cal_run          = calib_active;
endmodule : line_regs

// ### bench/line_side_model.sv
// Behavioural line-side device that senses the loop and obeys the minimum loop current and current-limit settings.
module line_side_model (
	// Settings from the bank.
	input  wire logic [1:0] min_loop_sel,
	input  wire logic       current_limit_en,
	// Raw line conditions chosen by the bench.
	input  wire logic [7:0] loop_raw,
	input  wire logic [7:0] volt_raw,
	input  wire logic       present,
	input  wire logic [3:0] trim,
	// Sensed values toward the bank.
	output logic      [7:0] loop_current_in,
	output logic      [7:0] line_voltage_in,
	output logic            loop_ok_in,
	output logic            line_present_in,
	output logic      [3:0] cal_trim_in
);
	timeunit 1ns;
	timeprecision 1ns;

	// Limiting holds the loop at 54 counts, the last one below 60 mA.
	always_comb begin
		loop_current_in = (current_limit_en && loop_raw > 8'h36) ? 8'h36 : loop_raw;
		loop_ok_in = present && (11 * loop_current_in >= 100 + 20 * min_loop_sel);
		line_present_in = present;
		line_voltage_in = volt_raw;
		cal_trim_in = trim;
	end
endmodule : line_side_model

// ### bench/line_regs_checker.sv
// Port-level assertions for the line register bank.
module line_regs_checker #(
	parameter int CAL_CYCLES = 2000
) (
	// Clock and reset.
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus signals watched.
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	// Line-side settings.
	input wire logic [1:0]  tipring_volt_sel,
	input wire logic [1:0]  min_loop_sel,
	input wire logic        current_limit_en,
	input wire logic        dc_impedance_sel,
	input wire logic        cal_run
);
	int run_cnt_q;

	// Length of the calibration run in progress, so long runs need no unrolled repetition.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_cnt_q <= 0;
		end else begin
			run_cnt_q <= cal_run ? run_cnt_q + 1 : 0;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_CAL_LEN: assert property ($past(aresetn) && $fell(cal_run) |-> run_cnt_q == CAL_CYCLES)
		else $error("calibration run length wrong");
	AST_CAL_MAX: assert property (run_cnt_q <= CAL_CYCLES)
		else $error("calibration runs too long");
	AST_SET_COMMIT: assert property ($past(aresetn) && $changed({tipring_volt_sel,
		min_loop_sel, current_limit_en, dc_impedance_sel}) |-> $rose(s_axi_bvalid))
		else $error("setting changed without a write");
	AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data not held");
	AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	AST_RD_DROP: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid && s_axi_arready)
		else $error("read answer not released");
	AST_WR_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
	AST_AR_READY: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("read address ready wrong");
	AST_RD_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits set");
endmodule : line_regs_checker

bind line_regs line_regs_checker #(.CAL_CYCLES(CAL_CYCLES)) i_line_regs_checker (
	.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .tipring_volt_sel(tipring_volt_sel),
	.min_loop_sel(min_loop_sel), .current_limit_en(current_limit_en),
	.dc_impedance_sel(dc_impedance_sel), .cal_run(cal_run));

// ### bench/tb.sv
// Self-checking bench for the line register bank.
`include "line_cfg.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] A_CAL = {`IDX_CAL, 2'b00};
	localparam logic [7:0] A_DCT = {`IDX_DCT, 2'b00};
	localparam logic [7:0] A_LOOP = {`IDX_LOOP, 2'b00};
	localparam logic [7:0] A_VOLT = {`IDX_VOLT, 2'b00};
	localparam logic [7:0] A_STAT = {`IDX_IRQ_STAT, 2'b00};
	localparam logic [7:0] A_MASK = {`IDX_IRQ_MASK, 2'b00};
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, irq, current_limit_en, dc_impedance_sel, cal_run, present;
	logic        loop_ok_in, line_present_in;
	logic [1:0]  s_axi_bresp, s_axi_rresp, tipring_volt_sel, min_loop_sel, r;
	logic [3:0]  s_axi_wstrb, trim, res, cal_trim_in;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, loop_raw, volt_raw, loop_current_in;
	logic [7:0]  line_voltage_in, d, q;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	int          n_fail, checked, cyc;

	line_regs #(.CAL_CYCLES(8)) i_line_regs (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .irq(irq),
		.tipring_volt_sel(tipring_volt_sel), .min_loop_sel(min_loop_sel),
		.current_limit_en(current_limit_en), .dc_impedance_sel(dc_impedance_sel),
		.cal_run(cal_run), .loop_current_in(loop_current_in), .line_voltage_in(line_voltage_in),
		.loop_ok_in(loop_ok_in), .line_present_in(line_present_in), .cal_trim_in(cal_trim_in));
	line_side_model i_line_side_model (.min_loop_sel(min_loop_sel),
		.current_limit_en(current_limit_en), .loop_raw(loop_raw), .volt_raw(volt_raw),
		.present(present), .trim(trim), .loop_current_in(loop_current_in),
		.line_voltage_in(line_voltage_in), .loop_ok_in(loop_ok_in),
		.line_present_in(line_present_in), .cal_trim_in(cal_trim_in));

	// Free-running 20 MHz clock.
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// Cuts a hung run short; the tests need well under two thousand cycles.
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end

	task final_report;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Expected loop reading for the raw loop and the current termination settings.
	function automatic logic [7:0] exp_loop(logic [7:0] raw, logic [7:0] set, logic on);
		logic [7:0] c;
		c = (set[1] && raw > 8'h36) ? 8'h36 : raw;
		return (on && 11 * c >= 100 + 20 * set[5:4]) ? c : 8'h00;
	endfunction : exp_loop

	// Write with both channels offered together; bready stands until bvalid is seen.
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	// Read with rready standing from the request until rvalid is seen.
	task rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		q = s_axi_rdata[7:0];
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	// Main sequence.
	initial begin
		void'($urandom(32'hB665B71B));
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, loop_raw, volt_raw, d} = '0;
		s_axi_wstrb = 4'hF;
		present = 1'b1;
		trim = 4'($urandom);
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (30) @(posedge aclk);
		rd(A_CAL);
		chk(q, {4'h0, trim});
		res = q[3:0];
		wr(A_MASK, 8'h01);
		@(posedge aclk);
		chk({7'h00, irq}, 8'h01);
		wr(A_MASK, 8'h00);
		@(posedge aclk);
		chk({7'h00, irq}, 8'h00);
		wr(A_MASK, 8'h01);
		rd(A_STAT);
		chk(q & 8'h01, 8'h01);
		repeat (2) @(posedge aclk);
		chk({7'h00, irq}, 8'h00);
		$display("test irq done");
		trim <= res ^ 4'($urandom_range(1, 15));
		wr(A_CAL, {4'h4, res});
		rd(A_CAL);
		chk({7'h00, q[7]}, 8'h01);
		wr(A_CAL, {4'h0, res});
		repeat (20) @(posedge aclk);
		rd(A_CAL);
		chk(q, {4'h0, trim});
		res = trim;
		wr(A_CAL, {4'h2, res});
		wr(A_CAL, {4'h6, res});
		repeat (12) begin
			@(posedge aclk);
			chk({7'h00, cal_run}, 8'h00);
		end
		rd(A_CAL);
		chk(q, {4'h6, res});
		wr(A_CAL, {4'h0, res});
		$display("test calibration done");
		for (int i = 0; i < 10; i++) begin
			d = (i == 0) ? 8'hF3 : (i == 1) ? 8'h00 : 8'($urandom) & 8'hF3;
			wr(A_DCT, d);
			@(posedge aclk);
			chk({tipring_volt_sel, min_loop_sel, 2'b00, current_limit_en, dc_impedance_sel}, d);
			rd(A_DCT);
			chk(q, d);
		end
		s_axi_wstrb <= 4'h0;
		wr(A_DCT, ~d & 8'hF3);
		chk({6'h00, r}, {6'h00, line_pkg::RESP_OKAY});
		s_axi_wstrb <= 4'hF;
		rd(A_DCT);
		chk(q, d);
		$display("test termination done");
		for (int i = 0; i < 12; i++) begin
			present <= (i % 4) != 3;
			loop_raw <= 8'($urandom_range(0, 80));
			volt_raw <= 8'($urandom) | 8'h01;
			repeat (6) @(posedge aclk);
			rd(A_LOOP);
			chk(q, exp_loop(loop_raw, d, present));
			rd(A_VOLT);
			chk(q, present ? volt_raw : 8'h00);
			wr(A_LOOP, 8'h5A);
			rd(A_LOOP);
			chk(q, exp_loop(loop_raw, d, present));
		end
		wr(A_MASK, 8'h02);
		present <= 1'b1;
		volt_raw <= 8'h30;
		repeat (6) @(posedge aclk);
		rd(A_STAT);
		volt_raw <= 8'hD0;
		repeat (6) @(posedge aclk);
		chk({7'h00, irq}, 8'h01);
		rd(A_STAT);
		chk(q & 8'h02, 8'h02);
		$display("test monitor done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(A_DCT);
		chk(q, `DCT_RESET);
		$display("test reset done");
		rd(8'h6C);
		chk(q, 8'h00);
		chk({6'h00, r}, {6'h00, line_pkg::RESP_OKAY});
		rd(8'hFC);
		chk({6'h00, r}, {6'h00, line_pkg::RESP_SLVERR});
		wr(8'hFC, 8'h11);
		chk({6'h00, r}, {6'h00, line_pkg::RESP_SLVERR});
		$display("test map done");
		final_report();
	end
endmodule : tb
